// ===== rcif_pkg.sv
package rcif_pkg;
  localparam int FLAG_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NREG = 3;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS_A = 8'hE9;
  localparam logic [7:0] IDX_FLAGS_B = 8'h91;
  localparam logic [7:0] IDX_ERRORS = 8'hBF;
  localparam logic [7:0] IDX_MASK_A = 8'hA0;
  localparam logic [7:0] IDX_MASK_B = 8'hA1;
  localparam logic [7:0] IDX_MASK_E = 8'hA2;
  // slot 0 = flags a, 1 = flags b, 2 = errors
  localparam logic [2:0][7:0] FLAG_IDX = {IDX_ERRORS, IDX_FLAGS_B, IDX_FLAGS_A};
  localparam logic [2:0][7:0] MASK_IDX = {IDX_MASK_E, IDX_MASK_B, IDX_MASK_A};
  localparam logic [2:0][7:0] VALID_BITS = {8'h7F, 8'h3F, 8'hFE};
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // field positions
  localparam int A_RX_READY = 2;
  localparam int A_DELIM = 1;
  localparam int B_RESUMED = 5;
  localparam int B_HALTED = 4;
  localparam int B_MANUAL = 3;
  localparam int B_IDLE = 2;
  localparam int B_SENT = 1;
  localparam int B_ACK_SENT = 0;
  localparam int E_REJECT = 6;
  localparam int E_TX_UNDER = 5;
  localparam int E_TX_OVER = 4;
  localparam int E_RX_UNDER = 3;
  localparam int E_RX_OVER = 2;
  localparam int E_ABORT = 1;
  localparam int E_LOCK = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [ADDR_W-1:0] rcif_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : rcif_addr
endpackage : rcif_pkg

// ===== rcif_top.sv
`timescale 1ns/1ps
module rcif_top #(
  parameter int FLAG_W = rcif_pkg::FLAG_W
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [rcif_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [rcif_pkg::DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [rcif_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [rcif_pkg::DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic rx_over_threshold_in,
  input wire logic rx_frame_done_in,
  input wire logic rx_more_frames_in,
  input wire logic frame_delimiter_in,
  input wire logic source_lookup_complete_in,
  input wire logic [3:0] rx_misc_events_in,
  input wire logic strobe_proc_resumed_in,
  input wire logic strobe_proc_halted_in,
  input wire logic strobe_proc_manual_irq_in,
  input wire logic radio_entered_idle_in,
  input wire logic frame_sent_in,
  input wire logic ack_frame_sent_in,
  input wire logic radio_disable_strobe_in,
  input wire logic radio_disabled_in,
  input wire logic send_ack_strobe_in,
  input wire logic send_ack_pending_strobe_in,
  input wire logic suppress_ack_strobe_in,
  input wire logic rx_active_in,
  input wire logic transmit_queue_underflow_in,
  input wire logic transmit_queue_overflow_in,
  input wire logic receive_queue_underflow_in,
  input wire logic receive_queue_overflow_in,
  input wire logic reception_aborted_in,
  input wire logic synth_lock_timeout_in,
  input wire logic synth_lock_lost_in,
  input wire logic rx_restart_in,
  output logic synth_fault_out,
  output logic irq_out,
  output logic irq_normal_out,
  output logic irq_error_out
);
  import rcif_pkg::*;

  if (FLAG_W != 8) begin : g_width_check
    $error("rcif_top serves only 8-bit flag registers");
  end

  ////////////////////////////////////////////////////////////////
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  ////////////////////////////////////////////////////////////////
  logic rx_ready;
  logic cmd_rejected;
  logic lock_cond;
  logic [2:0][7:0] stat;
  logic [2:0][7:0] stat_prev_reg;
  logic [2:0][7:0] rise;

  assign rx_ready = rx_over_threshold_in | rx_frame_done_in | rx_more_frames_in;
  assign cmd_rejected = (radio_disable_strobe_in & radio_disabled_in)
    | ((send_ack_strobe_in | send_ack_pending_strobe_in
    | suppress_ack_strobe_in) & ~rx_active_in);
  assign lock_cond = synth_lock_timeout_in | (synth_lock_lost_in & rx_active_in);

  assign stat[0] = {rx_misc_events_in, source_lookup_complete_in,
    rx_ready, frame_delimiter_in, 1'b0};
  assign stat[1] = {2'h0, strobe_proc_resumed_in, strobe_proc_halted_in,
    strobe_proc_manual_irq_in, radio_entered_idle_in,
    frame_sent_in, ack_frame_sent_in};
  assign stat[2] = {1'b0, cmd_rejected, transmit_queue_underflow_in,
    transmit_queue_overflow_in, receive_queue_underflow_in,
    receive_queue_overflow_in, reception_aborted_in, lock_cond};
  assign rise = stat & ~stat_prev_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      stat_prev_reg <= '0;
    end else begin
      stat_prev_reg <= stat;
    end
  end

  // lock fault held until the receiver is restarted
  logic synth_fault_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      synth_fault_reg <= 1'b0;
    end else if (lock_cond) begin
      synth_fault_reg <= 1'b1;
    end else if (rx_restart_in) begin
      synth_fault_reg <= 1'b0;
    end
  end
  assign synth_fault_out = synth_fault_reg;

  ////////////////////////////////////////////////////////////////
  logic wr_fire;
  logic wr_mapped;
  logic [2:0] wsel_flag;
  logic [2:0] wsel_mask;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  assign wr_fire = s_axi_awvalid_in & s_axi_wvalid_in & ~bvalid_reg;
  assign s_axi_awready_out = wr_fire;
  assign s_axi_wready_out = wr_fire;

  always_comb begin
    wsel_flag = '0;
    wsel_mask = '0;
    wr_mapped = 1'b0;
    for (int r = 0; r < NREG; r++) begin
      if (s_axi_awaddr_in == rcif_addr(FLAG_IDX[r])) begin
        wsel_flag[r] = wr_fire & s_axi_wstrb_in[0];
        wr_mapped = 1'b1;
      end else if (s_axi_awaddr_in == rcif_addr(MASK_IDX[r])) begin
        wsel_mask[r] = wr_fire & s_axi_wstrb_in[0];
        wr_mapped = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;

  ////////////////////////////////////////////////////////////////
  logic [2:0][7:0] flag_reg;
  logic [2:0][7:0] flag_next;
  logic [2:0][7:0] mask_reg;
  logic [2:0][7:0] clr;
  logic [2:0][7:0] pend_next;

  for (genvar r = 0; r < NREG; r++) begin : g_reg
    assign clr[r] = wsel_flag[r] ? (~s_axi_wdata_in[7:0] & VALID_BITS[r]) : 8'h00;
    // set wins over a clear in the same cycle
    assign flag_next[r] = ((flag_reg[r] & ~clr[r]) | rise[r]) & VALID_BITS[r];
    assign pend_next[r] = flag_next[r] & mask_reg[r];

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
        flag_reg[r] <= FLAG_RESET;
      end else begin
        flag_reg[r] <= flag_next[r];
      end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
        mask_reg[r] <= MASK_RESET;
      end else if (wsel_mask[r]) begin
        mask_reg[r] <= s_axi_wdata_in[7:0] & VALID_BITS[r];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  logic norm_fire;
  logic err_fire;
  logic irq_normal_reg;
  logic irq_error_reg;
  logic irq_level_reg;

  assign norm_fire = (|(rise[0] & mask_reg[0])) | (|(rise[1] & mask_reg[1]))
    | ((wsel_flag[0] | wsel_flag[1]) & (|pend_next[0] | |pend_next[1]));
  assign err_fire = (|(rise[2] & mask_reg[2]))
    | (wsel_flag[2] & (|pend_next[2]));

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_normal_reg <= 1'b0;
      irq_error_reg <= 1'b0;
      irq_level_reg <= 1'b0;
    end else begin
      irq_normal_reg <= norm_fire;
      irq_error_reg <= err_fire;
      irq_level_reg <= |pend_next;
    end
  end
  assign irq_normal_out = irq_normal_reg;
  assign irq_error_out = irq_error_reg;
  assign irq_out = irq_level_reg;

  ////////////////////////////////////////////////////////////////
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rd_byte;
  logic rd_mapped;
  logic rd_fire;

  assign rd_fire = s_axi_arvalid_in & ~rvalid_reg;
  assign s_axi_arready_out = ~rvalid_reg;

  always_comb begin
    rd_byte = 8'h00;
    rd_mapped = 1'b0;
    for (int r = 0; r < NREG; r++) begin
      if (s_axi_araddr_in == rcif_addr(FLAG_IDX[r])) begin
        rd_byte = flag_reg[r];
        rd_mapped = 1'b1;
      end else if (s_axi_araddr_in == rcif_addr(MASK_IDX[r])) begin
        rd_byte = mask_reg[r];
        rd_mapped = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n);

  rx_ready_set_a: assert property (
    (rx_more_frames_in && !stat_prev_reg[0][A_RX_READY]) |=> flag_reg[0][A_RX_READY])
    else $error("rx ready flag not set");
  delim_set_a: assert property (
    (frame_delimiter_in && !stat_prev_reg[0][A_DELIM]) |=> flag_reg[0][A_DELIM])
    else $error("delimiter flag not set");
  resumed_set_a: assert property (
    rise[1][B_RESUMED] |=> flag_reg[1][B_RESUMED])
    else $error("resumed flag not set");
  halted_set_a: assert property (
    rise[1][B_HALTED] |=> flag_reg[1][B_HALTED])
    else $error("halted flag not set");
  manual_set_a: assert property (
    rise[1][B_MANUAL] |=> flag_reg[1][B_MANUAL])
    else $error("manual flag not set");
  idle_set_a: assert property (
    (radio_entered_idle_in && !stat_prev_reg[1][B_IDLE]) |=> flag_reg[1][B_IDLE])
    else $error("idle flag not set");
  sent_set_a: assert property (
    rise[1][B_SENT] |=> flag_reg[1][B_SENT])
    else $error("sent flag not set");
  ack_set_a: assert property (
    rise[1][B_ACK_SENT] |=> flag_reg[1][B_ACK_SENT])
    else $error("ack flag not set");
  reject_set_a: assert property (
    (send_ack_strobe_in && !rx_active_in && !stat_prev_reg[2][E_REJECT])
    |=> flag_reg[2][E_REJECT])
    else $error("rejected strobe not flagged");
  abort_set_a: assert property (
    (reception_aborted_in && !stat_prev_reg[2][E_ABORT]) |=> flag_reg[2][E_ABORT])
    else $error("abort flag not set");
  lock_set_a: assert property (
    (synth_lock_timeout_in && !stat_prev_reg[2][E_LOCK]) |=> flag_reg[2][E_LOCK])
    else $error("lock flag not set");
  fault_hold_a: assert property (
    (synth_fault_out && !rx_restart_in) |=> synth_fault_out)
    else $error("lock fault dropped early");
  edge_only_a: assert property (
    (stat == stat_prev_reg && wsel_flag == 3'h0) |=> !irq_normal_out && !irq_error_out)
    else $error("interrupt without edge");
  mask_free_a: assert property (
    (rise[2][E_RX_UNDER] && !mask_reg[2][E_RX_UNDER]) |=> flag_reg[2][E_RX_UNDER])
    else $error("masked flag not updated");
  refire_a: assert property (
    (wsel_flag[0] && |(flag_reg[1] & mask_reg[1])) |=> irq_normal_out)
    else $error("no refire after clear");
  write_clear_a: assert property (
    (wsel_flag[2] && !s_axi_wdata_in[E_ABORT] && !rise[2][E_ABORT]) |=> !flag_reg[2][E_ABORT])
    else $error("write zero did not clear");
  write_keep_a: assert property (
    (wsel_flag[2] && s_axi_wdata_in[E_REJECT] && flag_reg[2][E_REJECT]) |=> flag_reg[2][E_REJECT])
    else $error("write one cleared a flag");
  reserved_zero_a: assert property (
    flag_reg[1][7:6] == 2'h0 && flag_reg[2][7] == 1'b0 && flag_reg[0][0] == 1'b0)
    else $error("reserved flag bit set");
  fifo_err_a: assert property (
    (rise[2][E_TX_UNDER:E_RX_OVER] != 4'h0)
    |=> (flag_reg[2][E_TX_UNDER:E_RX_OVER] & $past(rise[2][E_TX_UNDER:E_RX_OVER]))
    == $past(rise[2][E_TX_UNDER:E_RX_OVER]))
    else $error("fifo error not flagged");
  bresp_hold_a: assert property (
    (s_axi_bvalid_out && !s_axi_bready_in) |=> $stable(s_axi_bvalid_out))
    else $error("write response dropped");
endmodule : rcif_top

// ===== rcif_cpu_model.sv
`timescale 1ns/1ps
module rcif_cpu_model (
  input wire logic clk_in,
  output logic [11:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [11:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
    wstrb_out = 4'hF;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // released payloads are inverted so stale values never pass for live ones
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge clk_in);
      if (awvalid_out && awready_in) begin
        aw_done = 1'b1;
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (wvalid_out && wready_in) begin
        w_done = 1'b1;
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
    end
    bready_out <= 1'b1;
    do @(posedge clk_in); while (!bvalid_in);
    r = bresp_in;
    bready_out <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    do @(posedge clk_in); while (!arready_in);
    arvalid_out <= 1'b0;
    araddr_out <= ~a;
    rready_out <= 1'b1;
    do @(posedge clk_in); while (!rvalid_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask : rd
endmodule : rcif_cpu_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import rcif_pkg::*;
  logic clk_sys_in, resetn_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, fault, irq, irq_n, irq_e;
  logic [28:0] ev;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int bad_count = 0;
  int cmp_count = 0;
  int nrm_cnt = 0;
  int err_cnt = 0;
  int cyc = 0;

  rcif_cpu_model i_cpu (.clk_in(clk_sys_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
    .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
    .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
    .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));

  rcif_top i_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .rx_over_threshold_in(ev[0]), .rx_frame_done_in(ev[1]), .rx_more_frames_in(ev[2]),
    .frame_delimiter_in(ev[3]), .source_lookup_complete_in(ev[4]), .rx_misc_events_in(ev[8:5]),
    .strobe_proc_resumed_in(ev[9]), .strobe_proc_halted_in(ev[10]), .strobe_proc_manual_irq_in(ev[11]),
    .radio_entered_idle_in(ev[12]), .frame_sent_in(ev[13]), .ack_frame_sent_in(ev[14]),
    .radio_disable_strobe_in(ev[15]), .radio_disabled_in(ev[16]), .send_ack_strobe_in(ev[17]),
    .send_ack_pending_strobe_in(ev[18]), .suppress_ack_strobe_in(ev[19]), .rx_active_in(ev[20]),
    .transmit_queue_underflow_in(ev[21]), .transmit_queue_overflow_in(ev[22]),
    .receive_queue_underflow_in(ev[23]), .receive_queue_overflow_in(ev[24]), .reception_aborted_in(ev[25]),
    .synth_lock_timeout_in(ev[26]), .synth_lock_lost_in(ev[27]), .rx_restart_in(ev[28]),
    .synth_fault_out(fault), .irq_out(irq), .irq_normal_out(irq_n), .irq_error_out(irq_e));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    cyc++;
    if (irq_n === 1'b1) nrm_cnt++;
    if (irq_e === 1'b1) err_cnt++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : ad

  // flags expected from one pulse of p: {errors, flags b, flags a}
  function automatic logic [23:0] flags_of(input logic [28:0] p);
    logic rej;
    logic lk;
    rej = (p[15] & p[16]) | (|p[19:17] & !p[20]);
    lk = p[26] | (p[27] & p[20]);
    return {1'b0, rej, p[21], p[22], p[23], p[24], p[25], lk, 2'h0, p[9], p[10], p[11], p[12], p[13],
      p[14], p[8:5], p[4], |p[2:0], p[3], 1'b0};
  endfunction : flags_of

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic pulse(input logic [28:0] p);
    @(posedge clk_sys_in) ev <= p;
    @(posedge clk_sys_in) ev <= 29'h0;
    repeat (2) @(posedge clk_sys_in);
  endtask : pulse

  task automatic final_report;
    $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] seed, d;
    logic [1:0] r;
    logic [23:0] x;
    logic [28:0] p;
    logic [28:0] corner [6];
    int n0;
    corner = '{29'h1, 29'h2, 29'h4, 29'h12_0000, 29'h800_0000, 29'h8000};
    seed = 32'h0001_6D8A;
    ev = 29'h0;
    resetn_in = 1'b0;
    repeat (8) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    for (int s = 0; s < 3; s++) begin
      i_cpu.rd(ad(FLAG_IDX[s]), d, r);
      chk("flag reset", d, 32'h0);
      i_cpu.rd(ad(MASK_IDX[s]), d, r);
      chk("mask reset", d, 32'h0);
    end
    i_cpu.rd(12'hFFC, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    i_cpu.wr(12'hFFC, 32'h0, r);
    chk("unmapped wr", {30'h0, r}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      p = (i < 6) ? corner[i] : (seed[28:0] & 29'h0FFF_FFFF);
      pulse(p);
      x = flags_of(p);
      for (int s = 0; s < 3; s++) begin
        i_cpu.rd(ad(FLAG_IDX[s]), d, r);
        chk("flags", d, {24'h0, x[8*s+:8]});
        chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
        i_cpu.wr(ad(FLAG_IDX[s]), 32'hFF, r);
        chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
        i_cpu.rd(ad(FLAG_IDX[s]), d, r);
        chk("write one", d, {24'h0, x[8*s+:8]});
        i_cpu.wr(ad(FLAG_IDX[s]), 32'h0, r);
        i_cpu.rd(ad(FLAG_IDX[s]), d, r);
        chk("write zero", d, 32'h0);
      end
    end
    i_cpu.wr(ad(IDX_MASK_B), 32'h6, r);
    i_cpu.rd(ad(IDX_MASK_B), d, r);
    chk("mask b", d, 32'h6);
    n0 = nrm_cnt;
    @(posedge clk_sys_in) ev <= 29'h2000;
    repeat (8) @(posedge clk_sys_in);
    i_cpu.wr(ad(IDX_FLAGS_B), 32'h0, r);
    i_cpu.rd(ad(IDX_FLAGS_B), d, r);
    chk("held level", d, 32'h0);
    chk("one pulse", nrm_cnt - n0, 1);
    @(posedge clk_sys_in) ev <= 29'h0;
    n0 = nrm_cnt;
    pulse(29'h3000);
    #1 chk("irq level", irq, 1'b1);
    i_cpu.wr(ad(IDX_FLAGS_B), 32'hFB, r);
    repeat (3) @(posedge clk_sys_in);
    chk("refire", nrm_cnt - n0, 2);
    i_cpu.wr(ad(IDX_FLAGS_A), 32'hFF, r);
    repeat (3) @(posedge clk_sys_in);
    chk("refire a", nrm_cnt - n0, 3);
    pulse(29'h4000);
    chk("masked pulse", nrm_cnt - n0, 3);
    i_cpu.rd(ad(IDX_FLAGS_B), d, r);
    chk("masked flag", d, 32'h3);
    i_cpu.wr(ad(IDX_FLAGS_B), 32'h0, r);
    repeat (3) @(posedge clk_sys_in);
    #1 chk("irq low", irq, 1'b0);
    i_cpu.wr(ad(IDX_MASK_E), 32'h2, r);
    n0 = err_cnt;
    pulse(29'h200_0000);
    #1 chk("error pulse", err_cnt - n0, 1);
    chk("error irq", irq, 1'b1);
    pulse(29'h1000_0000);
    #1 chk("fault off", fault, 1'b0);
    pulse(29'h400_0000);
    #1 chk("fault set", fault, 1'b1);
    i_cpu.wr(ad(IDX_ERRORS), 32'h0, r);
    #1 chk("fault kept", fault, 1'b1);
    pulse(29'h1000_0000);
    #1 chk("fault clear", fault, 1'b0);
    chk("irq clear", irq, 1'b0);
    final_report();
  end
endmodule : tb
